// ### pkg/csc_regs.vh
/*
 * constants of the clock source and start-up controller: fuse codes,
 * source selects, start-up cycle counts and counter width.
 * assumes it is included by bare name from the rtl files.
 */
`ifndef CSC_REGS_VH
`define CSC_REGS_VH

// clock source fuse codes, as stored (zero means programmed)
`define CSC_SRC_EXT        4'h0
`define CSC_SRC_RC         4'h2
`define CSC_SRC_WDOG       4'h4
`define CSC_SRC_LFXTAL     4'h6
`define CSC_SRC_XTAL_BIT   3
`define CSC_SUT_RESERVED   2'h3
// shipped start-up code: longest reset delay
`define CSC_SUT_FACTORY    2'h2

// one-hot oscillator select bit positions
`define CSC_SEL_EXT        0
`define CSC_SEL_RC         1
`define CSC_SEL_WDOG       2
`define CSC_SEL_LFXTAL     3
`define CSC_SEL_XTAL       4
`define CSC_SEL_W          5

// counter width and cycle counts
`define CSC_CNT_W          16
`define CSC_CK_ZERO        16'h0000
`define CSC_CK_6           16'h0006
`define CSC_CK_14          16'h000E
`define CSC_CK_258         16'h0102
`define CSC_CK_1K          16'h0400
`define CSC_CK_16K         16'h4000
`define CSC_CK_32K         16'h8000
// watchdog oscillator cycles for the 4 ms / 4.1 ms and 64 ms / 65 ms delays
`define CSC_WDOG_4MS       16'h0200
`define CSC_WDOG_64MS      16'h2000

`endif

// ### rtl/csc_cycle_counter.v
/*
 * down counter that waits for a loaded number of tick pulses.
 * assumes tick is a one-cycle pulse synchronous to sys_clk.
 */
`include "csc_regs.vh"

module csc_cycle_counter (
	input  wire                  sys_clk,
	input  wire                  rst_b,
	input  wire                  load,
	input  wire [`CSC_CNT_W-1:0] target,
	input  wire                  tick,
	output reg                   done
);

	reg [`CSC_CNT_W-1:0] remain;

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			remain <= `CSC_CK_ZERO;
			done   <= 1'b1;
		end else if (load) begin
			remain <= target;
			done   <= (target == `CSC_CK_ZERO);
		end else if (tick && (remain != `CSC_CK_ZERO)) begin
			remain <= remain - 1'b1;
			done   <= (remain == {{(`CSC_CNT_W-1){1'b0}}, 1'b1});
		end
	end

endmodule // csc_cycle_counter

// ### rtl/csc_clock_ctrl.v
/*
 * clock source decode, start-up timing and clock domain enables.
 * assumes src_tick pulses once per cycle of the selected source and
 * wdog_tick once per watchdog oscillator cycle, both synchronous to
 * sys_clk; the enables drive latch-based clock gating cells.
 */
`include "csc_regs.vh"

module csc_clock_ctrl (
	input  wire                  sys_clk,
	input  wire                  rst_b,
	input  wire [3:0]            clock_source_fuses,
	input  wire [1:0]            startup_time_fuses,
	input  wire                  divide_by_eight_fuse,
	input  wire                  src_tick,
	input  wire                  wdog_tick,
	input  wire                  deep_sleep,
	input  wire                  stop_core,
	input  wire                  stop_peripheral,
	input  wire                  stop_converter,
	input  wire                  ext_int_in,
	output reg                   core_clock_en,
	output reg                   peripheral_clock_en,
	output reg                   program_memory_clock_en,
	output reg                   converter_clock_en,
	output reg [`CSC_SEL_W-1:0]  oscillator_select,
	output reg [1:0]             crystal_band,
	output reg                   divide_by_eight,
	output reg                   config_invalid,
	output reg                   startup_busy,
	output reg                   ext_int_wake
);

	localparam [7:0] ST_BOOT  = 8'h01;
	localparam [7:0] ST_LOAD  = 8'h02;
	localparam [7:0] ST_SRC   = 8'h04;
	localparam [7:0] ST_WDOG  = 8'h08;
	localparam [7:0] ST_RUN   = 8'h10;
	localparam [7:0] ST_SLEEP = 8'h20;
	localparam [7:0] ST_WAKE  = 8'h40;
	localparam [7:0] ST_BAD   = 8'h80;

	reg  [7:0]            state;
	reg  [7:0]            next_state;
	reg  [3:0]            cfg_src;
	reg  [1:0]            cfg_sut;
	reg                   cfg_div8;
	reg                   cfg_bad;
	reg  [`CSC_CNT_W-1:0] wake_ck;
	reg  [`CSC_CNT_W-1:0] reset_ck;
	reg  [`CSC_CNT_W-1:0] wdog_ck;
	reg  [`CSC_SEL_W-1:0] sel;
	reg                   src_load;
	reg  [`CSC_CNT_W-1:0] src_target;
	reg                   wdog_load;
	wire                  src_done;
	wire                  wdog_done;
	wire                  run_next;

	////////////////////////////////////////////////////////////////////////
	// fuse capture: only the boot state follows the pins

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_src  <= `CSC_SRC_RC;
			cfg_sut  <= `CSC_SUT_FACTORY;
			cfg_div8 <= 1'b1;
		end else if (state == ST_BOOT) begin
			cfg_src  <= clock_source_fuses;
			cfg_sut  <= startup_time_fuses;
			cfg_div8 <= ~divide_by_eight_fuse;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// decode of source and start-up codes

	always @* begin
		cfg_bad  = 1'b0;
		wake_ck  = `CSC_CK_6;
		reset_ck = `CSC_CK_14;
		wdog_ck  = `CSC_CK_ZERO;
		sel      = {`CSC_SEL_W{1'b0}};
		case (cfg_src)
		`CSC_SRC_EXT, `CSC_SRC_RC, `CSC_SRC_WDOG: begin
			if (cfg_src == `CSC_SRC_EXT)
				sel[`CSC_SEL_EXT] = 1'b1;
			else if (cfg_src == `CSC_SRC_RC)
				sel[`CSC_SEL_RC] = 1'b1;
			else
				sel[`CSC_SEL_WDOG] = 1'b1;
			case (cfg_sut)
			2'h0: wdog_ck = `CSC_CK_ZERO;
			2'h1: wdog_ck = `CSC_WDOG_4MS;
			2'h2: wdog_ck = `CSC_WDOG_64MS;
			default: cfg_bad = 1'b1;
			endcase
		end
		`CSC_SRC_LFXTAL: begin
			sel[`CSC_SEL_LFXTAL] = 1'b1;
			reset_ck = `CSC_CK_ZERO;
			case (cfg_sut)
			2'h0: begin
				wake_ck = `CSC_CK_1K;
				wdog_ck = `CSC_WDOG_4MS;
			end
			2'h1: begin
				wake_ck = `CSC_CK_1K;
				wdog_ck = `CSC_WDOG_64MS;
			end
			2'h2: begin
				wake_ck = `CSC_CK_32K;
				wdog_ck = `CSC_WDOG_64MS;
			end
			default: cfg_bad = 1'b1;
			endcase
		end
		default: begin
			if (cfg_src[`CSC_SRC_XTAL_BIT]) begin
				sel[`CSC_SEL_XTAL] = 1'b1;
				case ({cfg_src[0], cfg_sut})
				3'h0: begin
					wake_ck = `CSC_CK_258;
					wdog_ck = `CSC_WDOG_4MS;
				end
				3'h1: begin
					wake_ck = `CSC_CK_258;
					wdog_ck = `CSC_WDOG_64MS;
				end
				3'h2: wake_ck = `CSC_CK_1K;
				3'h3: begin
					wake_ck = `CSC_CK_1K;
					wdog_ck = `CSC_WDOG_4MS;
				end
				3'h4: begin
					wake_ck = `CSC_CK_1K;
					wdog_ck = `CSC_WDOG_64MS;
				end
				3'h5: wake_ck = `CSC_CK_16K;
				3'h6: begin
					wake_ck = `CSC_CK_16K;
					wdog_ck = `CSC_WDOG_4MS;
				end
				default: begin
					wake_ck = `CSC_CK_16K;
					wdog_ck = `CSC_WDOG_64MS;
				end
				endcase
			end else begin
				cfg_bad = 1'b1;
			end
		end
		endcase
		if (cfg_bad)
			sel = {`CSC_SEL_W{1'b0}};
	end

	////////////////////////////////////////////////////////////////////////
	// start-up sequencer

	always @* begin
		next_state = state;
		src_load   = 1'b0;
		src_target = reset_ck;
		wdog_load  = 1'b0;
		case (state)
		ST_BOOT: next_state = ST_LOAD;
		ST_LOAD: begin
			if (cfg_bad) begin
				next_state = ST_BAD;
			end else begin
				src_load   = 1'b1;
				next_state = ST_SRC;
			end
		end
		ST_SRC: begin
			if (src_done) begin
				wdog_load  = 1'b1;
				next_state = ST_WDOG;
			end
		end
		ST_WDOG: begin
			if (wdog_done)
				next_state = ST_RUN;
		end
		ST_RUN: begin
			if (deep_sleep)
				next_state = ST_SLEEP;
		end
		ST_SLEEP: begin
			if (!deep_sleep || ext_int_in) begin
				src_load   = 1'b1;
				src_target = wake_ck;
				next_state = ST_WAKE;
			end
		end
		ST_WAKE: begin
			if (src_done)
				next_state = ST_RUN;
		end
		ST_BAD: next_state = ST_BAD;
		default: next_state = ST_BOOT;
		endcase
	end

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			state <= ST_BOOT;
		else
			state <= next_state;
	end

	csc_cycle_counter u_src_count (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.load    (src_load),
		.target  (src_target),
		.tick    (src_tick),
		.done    (src_done)
	);

	// the real-time delay runs on the watchdog ticks, not the source
	csc_cycle_counter u_wdog_count (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.load    (wdog_load),
		.target  (wdog_ck),
		.tick    (wdog_tick),
		.done    (wdog_done)
	);

	////////////////////////////////////////////////////////////////////////
	// domain enables: registered so the gating cells see no glitch

	assign run_next = (next_state == ST_RUN);

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			core_clock_en           <= 1'b0;
			peripheral_clock_en     <= 1'b0;
			program_memory_clock_en <= 1'b0;
			converter_clock_en      <= 1'b0;
			oscillator_select       <= {`CSC_SEL_W{1'b0}};
			crystal_band            <= 2'h0;
			divide_by_eight         <= 1'b0;
			config_invalid          <= 1'b0;
			startup_busy            <= 1'b1;
			ext_int_wake            <= 1'b0;
		end else begin
			core_clock_en           <= run_next & ~stop_core;
			program_memory_clock_en <= run_next & ~stop_core;
			peripheral_clock_en     <= run_next & ~stop_peripheral;
			converter_clock_en      <= run_next & ~stop_converter;
			// oscillator stays off in power-down and for bad codes
			if ((state == ST_BOOT) || (state == ST_BAD) ||
			    (next_state == ST_SLEEP) || (next_state == ST_BAD))
				oscillator_select <= {`CSC_SEL_W{1'b0}};
			else
				oscillator_select <= sel;
			crystal_band    <= sel[`CSC_SEL_XTAL] ? cfg_src[2:1] : 2'h0;
			divide_by_eight <= cfg_div8 & ~cfg_bad;
			config_invalid  <= (state == ST_BAD) || (next_state == ST_BAD);
			startup_busy    <= ~run_next & (next_state != ST_SLEEP) &
			                   (next_state != ST_BAD);
			// interrupt sensed straight from the pin, even with io clock off
			ext_int_wake    <= ext_int_in & (state == ST_SLEEP);
		end
	end

endmodule // csc_clock_ctrl

// ### testbench/csc_clock_ctrl_asserts.sv
/*
 * port checker of the clock source and start-up controller.
 * assumes it is bound to the controller top and sees its ports only.
 */
`include "csc_regs.vh"

module csc_clock_ctrl_asserts (
	input wire                  sys_clk,
	input wire                  rst_b,
	input wire                  stop_core,
	input wire                  stop_peripheral,
	input wire                  core_clock_en,
	input wire                  peripheral_clock_en,
	input wire                  program_memory_clock_en,
	input wire                  converter_clock_en,
	input wire [`CSC_SEL_W-1:0] oscillator_select,
	input wire [1:0]            crystal_band,
	input wire                  divide_by_eight,
	input wire                  config_invalid,
	input wire                  startup_busy
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	////////////////////////////////
	a_busy_holds_off: assert property (startup_busy |-> !core_clock_en &&
		!peripheral_clock_en && !converter_clock_en)
		else $error("clock domain enabled during start-up");
	a_flash_follows_core: assert property (
		program_memory_clock_en == core_clock_en)
		else $error("flash clock differs from core clock");
	a_invalid_no_osc: assert property (config_invalid |->
		oscillator_select == 5'h00 && !core_clock_en)
		else $error("oscillator chosen for invalid setting");
	a_select_one_hot: assert property ($onehot0(oscillator_select))
		else $error("oscillator select not one-hot");
	a_band_xtal_only: assert property (oscillator_select != 5'h00 &&
		!oscillator_select[`CSC_SEL_XTAL] |-> crystal_band == 2'h0)
		else $error("crystal band outside crystal mode");
	a_config_static: assert property ($past(rst_b) &&
		!$past(startup_busy) |-> $stable(crystal_band) &&
		($stable(oscillator_select) || oscillator_select == 5'h00 ||
		$past(oscillator_select) == 5'h00))
		else $error("configuration moved after boot");
	a_core_stops: assert property (stop_core ##1 stop_core |->
		!core_clock_en)
		else $error("core clock runs while stopped");
	a_release_together: assert property ($rose(core_clock_en) &&
		$past(startup_busy) && !$past(stop_peripheral) |->
		peripheral_clock_en)
		else $error("domains not released together");
	a_div_valid: assert property (divide_by_eight |-> !config_invalid)
		else $error("divide by eight on invalid setting");
endmodule // csc_clock_ctrl_asserts

bind csc_clock_ctrl csc_clock_ctrl_asserts csc_clock_ctrl_asserts_inst (
	.sys_clk, .rst_b, .stop_core, .stop_peripheral, .core_clock_en,
	.peripheral_clock_en, .program_memory_clock_en, .converter_clock_en,
	.oscillator_select, .crystal_band, .divide_by_eight, .config_invalid,
	.startup_busy);

// ### testbench/csc_src_model.sv
/*
 * model of the selected oscillator and the watchdog oscillator.
 * assumes sys_clk runs far faster than either oscillator.
 */
module csc_src_model (
	input  wire       sys_clk,
	input  wire       rst_b,
	input  wire [4:0] oscillator_select,
	output logic      src_tick,
	output logic      wdog_tick
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] phase;
	////////////////////////////////
	// an unselected source stands still, so no pulse is given for it
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			phase <= 4'h0;
			src_tick <= 1'b0;
			wdog_tick <= 1'b0;
		end else begin
			phase <= (phase == 4'hB) ? 4'h0 : phase + 4'h1;
			src_tick <= (phase % 4'h6 == 4'h5) && |oscillator_select;
			wdog_tick <= (phase % 4'h3 == 4'h0);
		end
	end
endmodule // csc_src_model

// ### testbench/tb_top.sv
/*
 * scenario bench of the clock source and start-up controller.
 * assumes the source model supplies both tick streams.
 */
`include "csc_regs.vh"
`define TB_CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
	errors++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       sys_clk = 1'b0;
	logic       rst_b = 1'b0;
	logic [3:0] clock_source_fuses = 4'h2;
	logic [1:0] startup_time_fuses = 2'h0;
	logic       divide_by_eight_fuse = 1'b0;
	logic       deep_sleep = 1'b0;
	logic       stop_core = 1'b0;
	logic       stop_peripheral = 1'b0;
	logic       stop_converter = 1'b0;
	logic       ext_int_in = 1'b0;
	logic       src_tick, wdog_tick, core_clock_en, peripheral_clock_en;
	logic       program_memory_clock_en, converter_clock_en, config_invalid;
	logic       divide_by_eight, startup_busy, ext_int_wake;
	logic [4:0] oscillator_select;
	logic [1:0] crystal_band;
	int         errors = 0;
	int         samples_checked = 0;
	int         src_seen = 0;
	int         wdog_seen = 0;
	int         s0, w0, i;
	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		src_seen <= src_seen + src_tick;
		wdog_seen <= wdog_seen + wdog_tick;
	end
	csc_clock_ctrl csc_clock_ctrl_inst (.sys_clk, .rst_b, .clock_source_fuses,
		.startup_time_fuses, .divide_by_eight_fuse, .src_tick, .wdog_tick,
		.deep_sleep, .stop_core, .stop_peripheral, .stop_converter,
		.ext_int_in, .core_clock_en, .peripheral_clock_en,
		.program_memory_clock_en, .converter_clock_en, .oscillator_select,
		.crystal_band, .divide_by_eight, .config_invalid, .startup_busy,
		.ext_int_wake);
	csc_src_model csc_src_model_inst (.sys_clk, .rst_b, .oscillator_select,
		.src_tick, .wdog_tick);
	////////////////////////////////
	task report_and_stop;
		if (errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task boot(input logic [3:0] f, input logic [1:0] s, input logic d);
		@(posedge sys_clk);
		rst_b <= 1'b0;
		clock_source_fuses <= f;
		startup_time_fuses <= s;
		divide_by_eight_fuse <= d;
		repeat (8) @(posedge sys_clk);
		rst_b <= 1'b1;
		#1;
		s0 = src_seen;
		w0 = wdog_seen;
	endtask
	// bounded wait; sampled just after each edge so counts have landed
	task wait_run;
		#1;
		for (i = 0; i < 30000 && core_clock_en !== 1'b1; i++) begin
			@(posedge sys_clk);
			#1;
		end
		if (core_clock_en !== 1'b1) begin
			errors++;
			report_and_stop;
		end
	endtask
	task t_codes;
		int k;
		for (k = 0; k < 8; k++) begin
			boot(k[3:0], 2'h0, 1'b1);
			repeat (4) @(posedge sys_clk);
			#1;
			`TB_CHK(config_invalid, k[0])
			`TB_CHK(oscillator_select, k[0] ? 5'h00 : 5'h01 << k[2:1])
		end
		boot(`CSC_SRC_RC, `CSC_SUT_RESERVED, 1'b0);
		repeat (4) @(posedge sys_clk);
		#1;
		`TB_CHK({config_invalid, oscillator_select}, 6'h20)
	endtask
	task t_rc_boot;
		boot(`CSC_SRC_RC, 2'h0, 1'b0);
		wait_run;
		`TB_CHK(src_seen - s0, 14)
		`TB_CHK(oscillator_select, 5'h02)
		`TB_CHK(divide_by_eight, 1'b1)
		`TB_CHK({peripheral_clock_en, converter_clock_en}, 2'h3)
		`TB_CHK(startup_busy, 1'b0)
	endtask
	task t_rc_wdog(input logic [1:0] s, input logic d, input int n);
		boot(`CSC_SRC_RC, s, d);
		for (i = 0; i < 400 && src_seen - s0 < 14; i++) begin
			@(posedge sys_clk);
			#1;
		end
		if (src_seen - s0 < 14) begin
			errors++;
			report_and_stop;
		end
		w0 = wdog_seen;
		wait_run;
		`TB_CHK((wdog_seen - w0) inside {[n:n+3]}, 1'b1)
		`TB_CHK(divide_by_eight, ~d)
	endtask
	// wk is the expected wake count; zero skips the wake
	task t_xtal(input logic [3:0] f, input logic [1:0] s, input int wk);
		boot(f, s, 1'b0);
		repeat (4) @(posedge sys_clk);
		#1;
		`TB_CHK(oscillator_select, 5'h10)
		`TB_CHK(crystal_band, f[2:1])
		wait_run;
		`TB_CHK(src_seen - s0, 14)
		if (wk > 0) begin
			@(posedge sys_clk);
			deep_sleep <= 1'b1;
			repeat (4) @(posedge sys_clk);
			deep_sleep <= 1'b0;
			#1;
			s0 = src_seen;
			wait_run;
			`TB_CHK((src_seen - s0) inside {[wk:wk+1]}, 1'b1)
		end
	endtask
	task t_sleep;
		boot(`CSC_SRC_RC, 2'h0, 1'b0);
		wait_run;
		@(posedge sys_clk);
		stop_core <= 1'b1;
		clock_source_fuses <= `CSC_SRC_EXT;
		repeat (3) @(posedge sys_clk);
		#1;
		`TB_CHK({core_clock_en, program_memory_clock_en}, 2'h0)
		`TB_CHK({peripheral_clock_en, converter_clock_en}, 2'h3)
		@(posedge sys_clk);
		stop_core <= 1'b0;
		stop_peripheral <= 1'b1;
		stop_converter <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		`TB_CHK({core_clock_en, peripheral_clock_en}, 2'h2)
		`TB_CHK(converter_clock_en, 1'b0)
		`TB_CHK(oscillator_select, 5'h02)
		@(posedge sys_clk);
		stop_peripheral <= 1'b0;
		stop_converter <= 1'b0;
		deep_sleep <= 1'b1;
		repeat (4) @(posedge sys_clk);
		#1;
		`TB_CHK(core_clock_en, 1'b0)
		@(posedge sys_clk);
		deep_sleep <= 1'b0;
		#1;
		s0 = src_seen;
		w0 = wdog_seen;
		wait_run;
		`TB_CHK((src_seen - s0) inside {[6:7]}, 1'b1)
		`TB_CHK(wdog_seen - w0 < 40, 1'b1)
		@(posedge sys_clk);
		deep_sleep <= 1'b1;
		repeat (4) @(posedge sys_clk);
		ext_int_in <= 1'b1;
		@(posedge sys_clk);
		#1;
		`TB_CHK(ext_int_wake, 1'b1)
		wait_run;
		`TB_CHK(core_clock_en, 1'b1)
		@(posedge sys_clk);
		deep_sleep <= 1'b0;
		ext_int_in <= 1'b0;
	endtask
	initial begin
		t_codes;
		t_rc_boot;
		t_rc_wdog(2'h1, 1'b1, `CSC_WDOG_4MS);
		t_rc_wdog(`CSC_SUT_FACTORY, 1'b0, `CSC_WDOG_64MS);
		t_xtal(4'hB, 2'h1, 0);
		t_xtal(4'hC, 2'h2, `CSC_CK_1K);
		t_sleep;
		report_and_stop;
	end
	// a hang counts as a mismatch
	initial begin
		#2_000_000;
		errors++;
		report_and_stop;
	end
endmodule // tb_top
